// File: pkg/mode_ctrl_defs.vh
// Purpose: constants for the gate driver mode controller
// Assumes: 25 MHz system clock (40 ns period)
// Notes: times in ns, cycle counts derived from them except the watchdog period
`ifndef MODE_CTRL_DEFS_VH
`define MODE_CTRL_DEFS_VH
`define CLK_PERIOD_NS 40
// enable-low filter, longest time 8 us, rounded down
`define ENL_FILTER_NS 8000
`define ENL_FILTER_CYC (`ENL_FILTER_NS / `CLK_PERIOD_NS)
// extra sleep delay beyond the cross-current time, 3 us least
`define SLEEP_EXTRA_NS 3000
`define SLEEP_EXTRA_CYC \
   ((`SLEEP_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// spi setup time before normal mode (value of our choosing)
`define SPI_SETUP_NS 10000
`define SPI_SETUP_CYC \
   ((`SPI_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// default watchdog period in cycles (value of our choosing)
`define WD_PERIOD_CYC 2500
// frame kinds
`define FR_READ 2'h0
`define FR_WRITE 2'h1
`define FR_CLEAR 2'h2
// register addresses used by the exit sequence
`define ADDR_GEN_CTRL1 6'h00
`define ADDR_GEN_STAT 6'h30
// general control one: trigger bit position
`define WATCHDOG_TRIGGER_BIT_BIT 0
// exit sequence steps
`define EX_IDLE 2'h0
`define EX_CLEARED 2'h1
`define EX_TRIG1 2'h2
`endif

// File: rtl/en_sync_filter.v
// Purpose: three-stage synchroniser and low-pulse filter for enable
// Assumes: enable pin is asynchronous to clk_sys
// Notes: filtered level drops only after a low longer than the filter
`timescale 1ns/1ps
module en_sync_filter #(
   parameter FILT_CYC = 200
)(
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // pin and result
   input wire en_pin,
   output reg en_low_seen,
   output reg en_filt
);
   reg s1, s2, s3;
   reg [15:0] low_cnt;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         low_cnt <= 16'h0000;
         en_filt <= 1'b0;
         en_low_seen <= 1'b1;
      end
      else
      begin
         s1 <= en_pin;
         s2 <= s1;
         s3 <= s2;
         // only act once stages two and three agree
         if (s2 == s3)
         begin
            en_low_seen <= ~s3;
            if (s3)
            begin
               low_cnt <= 16'h0000;
               en_filt <= 1'b1;
            end
            // short lows never reach the filtered level
            else if (low_cnt >= FILT_CYC[15:0] - 16'h0001)
               en_filt <= 1'b0;
            else
               low_cnt <= low_cnt + 16'h0001;
         end
      end
   end
endmodule // en_sync_filter

// File: rtl/delay_timer.v
// Purpose: loadable down counter with a done pulse
// Assumes: load has priority over counting
// Notes: done pulses one cycle when count reaches one
`timescale 1ns/1ps
module delay_timer #(
   parameter W = 16
)(
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // control
   input wire load,
   input wire [W-1:0] value,
   input wire stop,
   output reg busy,
   output reg done
);
   reg [W-1:0] cnt;
   always @(posedge clk_sys)
   begin
      if (rst || stop)
      begin
         cnt <= {W{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (load)
      begin
         cnt <= value;
         busy <= 1'b1;
         done <= 1'b0;
      end
      else if (busy && cnt <= {{(W-1){1'b0}}, 1'b1})
      begin
         busy <= 1'b0;
         done <= 1'b1;
      end
      else
      begin
         done <= 1'b0;
         if (busy)
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // delay_timer

// File: rtl/gate_driver_mode_control.v
// Purpose: mode and reset control of a multi half-bridge gate driver
// Assumes: frames arrive decoded as one-cycle strobes on clk_sys
// Notes: logic supply reset comes in on rst (synchronous, high)
//
// Notes on behaviour
// - normal mode only after enable high plus spi setup time.
// - in normal mode drivers enabled, configuration writes accepted.
// - enable low in normal mode delays sleep by longest cross-current time plus 3 us; in setup or fail-safe, sleep follows at once.
// - sleep entry returns all registers to reset values.
// - sleep connects gate pull-down resistors on all gate outputs.
// - enable low shorter than filter time causes no sleep or reset.
// - frames during the sleep delay are ignored.
// - watchdog error enters fail-safe, sets flag, discharges actively.
// - after discharge, bridge goes passive, gates latched off, pump off.
// - foreign frame during exit keeps fail-safe; sequence restarts.
// - fail-safe holds control defaults except trigger, offset, amps.
// - fail-safe discards other writes and clears, sets serial error.
// - status clear in fail-safe leaves failure flags unchanged.
// - reads before exit sequence start set no serial error.
// - pump undervoltage set in fail-safe; clear status after exit.
// - logic supply loss resets logic and switches outputs off.
// - after power-on reset the negated power-on flag reads 0.
// - battery supply drop does not disturb logic state.
// - clearing status sets negated power-on flag to 1.
// - enable low resets logic; flag reads 0 after next normal entry.
`timescale 1ns/1ps
`include "mode_ctrl_defs.vh"
module gate_driver_mode_control #(
   parameter CTRL_W = 16,
   parameter [CTRL_W-1:0] CTRL_RESET = 16'h0000,
   parameter [CTRL_W-1:0] KEEP_MASK = 16'h000f,
   parameter FILT_CYC = `ENL_FILTER_CYC,
   parameter SETUP_CYC = `SPI_SETUP_CYC,
   parameter WD_CYC = `WD_PERIOD_CYC
)(
   // clock and reset (logic supply power-on reset)
   input wire clk_sys,
   input wire rst,
   // enable pin, asynchronous
   input wire en_pin,
   // decoded serial frame strobe
   input wire frame_valid,
   input wire [1:0] frame_kind,
   input wire [5:0] frame_addr,
   input wire [CTRL_W-1:0] frame_data,
   // watchdog error event, bridge timing and failure flags
   input wire watchdog_error,
   input wire [15:0] bridge_cross_current_time,
   input wire [15:0] failure_flags_in,
   // mode and driver outputs
   output reg normal_mode,
   output reg sleep_mode,
   output reg fail_safe_mode,
   output reg drivers_enabled,
   output reg active_discharge,
   output reg passive_mode,
   output reg gate_pulldown_on,
   output reg charge_pump_on,
   output reg frame_accept,
   // register contents
   output reg [CTRL_W-1:0] general_control_one,
   output reg [15:0] general_status_register,
   output reg fail_safe_flag,
   output reg serial_error_flag,
   output reg charge_pump_undervoltage_flag,
   output reg negated_power_on_flag
);
   localparam ST_SLEEP = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_NORMAL = 3'h2;
   localparam ST_DSLEEP = 3'h3;
   localparam ST_FS_DIS = 3'h4;
   localparam ST_FS_PASS = 3'h5;
   localparam [15:0] SLEEP_EXTRA = `SLEEP_EXTRA_CYC;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] exit_step;
   reg [15:0] wd_cnt;
   wire en_filt;
   wire en_low_seen;
   wire tmr_busy;
   wire tmr_done;
   reg tmr_load;
   reg [15:0] tmr_value;
   wire fr_write = frame_valid && frame_kind == `FR_WRITE;
   wire fr_clear = frame_valid && frame_kind == `FR_CLEAR;
   wire fr_read = frame_valid && frame_kind == `FR_READ;
   wire wr_ctrl1 = fr_write && frame_addr == `ADDR_GEN_CTRL1;
   wire clr_stat = fr_clear && frame_addr == `ADDR_GEN_STAT;
   wire trig_val = frame_data[`WATCHDOG_TRIGGER_BIT_BIT];
   wire in_fs = state == ST_FS_DIS || state == ST_FS_PASS;
   // only the trigger bit may change in fail-safe
   wire [CTRL_W-1:0] trig_only_mask = {{(CTRL_W-1){1'b0}}, 1'b1};
   wire trig_only = wr_ctrl1 &&
      ((frame_data ^ general_control_one) & ~trig_only_mask) ==
      {CTRL_W{1'b0}};
   wire fs_bad = in_fs && frame_valid && !clr_stat && !trig_only &&
      !(fr_read && exit_step == `EX_IDLE);

   en_sync_filter #(
      .FILT_CYC(FILT_CYC)
   ) u_en (
      .clk_sys(clk_sys),
      .rst(rst),
      .en_pin(en_pin),
      .en_low_seen(en_low_seen),
      .en_filt(en_filt)
   );

   delay_timer #(
      .W(16)
   ) u_tmr (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(tmr_load),
      .value(tmr_value),
      .stop(1'b0),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   always @*
   begin
      next_state = state;
      tmr_load = 1'b0;
      tmr_value = 16'h0000;
      case (state)
         ST_SLEEP:
            if (en_filt)
            begin
               next_state = ST_SETUP;
               tmr_load = 1'b1;
               tmr_value = SETUP_CYC[15:0];
            end
         ST_SETUP:
            if (!en_filt)
               next_state = ST_SLEEP;
            else if (tmr_done)
               next_state = ST_NORMAL;
         ST_NORMAL:
            if (!en_filt)
            begin
               next_state = ST_DSLEEP;
               tmr_load = 1'b1;
               tmr_value = bridge_cross_current_time + SLEEP_EXTRA;
            end
            else if (watchdog_error)
            begin
               next_state = ST_FS_DIS;
               tmr_load = 1'b1;
               tmr_value = bridge_cross_current_time;
            end
         ST_DSLEEP:
            if (tmr_done)
               next_state = ST_SLEEP;
         ST_FS_DIS:
            if (!en_filt)
               next_state = ST_SLEEP;
            else if (tmr_done)
               next_state = ST_FS_PASS;
         ST_FS_PASS:
            if (!en_filt)
               next_state = ST_SLEEP;
            else if (exit_step == `EX_TRIG1 && wr_ctrl1 && !trig_val &&
               trig_only)
               next_state = ST_NORMAL;
         default:
            next_state = ST_SLEEP;
      endcase
   end

   always @(posedge clk_sys)
   begin
      // supply reset clears all and switches outputs off
      // only the logic supply reset reaches this state
      if (rst)
      begin
         state <= ST_SLEEP;
         exit_step <= `EX_IDLE;
         wd_cnt <= 16'h0000;
         general_control_one <= CTRL_RESET;
         general_status_register <= 16'h0000;
         fail_safe_flag <= 1'b0;
         serial_error_flag <= 1'b0;
         charge_pump_undervoltage_flag <= 1'b0;
         negated_power_on_flag <= 1'b0;
         normal_mode <= 1'b0;
         sleep_mode <= 1'b1;
         fail_safe_mode <= 1'b0;
         drivers_enabled <= 1'b0;
         active_discharge <= 1'b0;
         passive_mode <= 1'b0;
         gate_pulldown_on <= 1'b1;
         charge_pump_on <= 1'b0;
         frame_accept <= 1'b0;
      end
      else
      begin
         state <= next_state;
         normal_mode <= next_state == ST_NORMAL;
         sleep_mode <= next_state == ST_SLEEP;
         fail_safe_mode <= next_state == ST_FS_DIS ||
            next_state == ST_FS_PASS;
         drivers_enabled <= next_state == ST_NORMAL;
         active_discharge <= next_state == ST_DSLEEP ||
            next_state == ST_FS_DIS;
         passive_mode <= next_state == ST_FS_PASS;
         charge_pump_on <= next_state == ST_NORMAL ||
            next_state == ST_DSLEEP || next_state == ST_FS_DIS;
         gate_pulldown_on <= next_state == ST_SLEEP;
         // frames ignored while sleep is pending
         frame_accept <= next_state == ST_NORMAL || next_state == ST_FS_DIS
            || next_state == ST_FS_PASS;
         if (state == ST_FS_PASS)
            charge_pump_undervoltage_flag <= 1'b1;
         if (state == ST_SLEEP)
         begin
            exit_step <= `EX_IDLE;
            wd_cnt <= 16'h0000;
            general_control_one <= CTRL_RESET;
            general_status_register <= 16'h0000;
            fail_safe_flag <= 1'b0;
            serial_error_flag <= 1'b0;
            charge_pump_undervoltage_flag <= 1'b0;
            negated_power_on_flag <= 1'b0;
         end
         else if (state == ST_NORMAL)
         begin
            if (watchdog_error && en_filt)
               fail_safe_flag <= 1'b1;
            general_status_register <= general_status_register |
               failure_flags_in;
            if (wr_ctrl1)
               general_control_one <= frame_data;
            if (clr_stat)
            begin
               // clear sets power-on flag; new events win
               general_status_register <= failure_flags_in;
               negated_power_on_flag <= 1'b1;
               charge_pump_undervoltage_flag <=
                  state == ST_FS_PASS;
               fail_safe_flag <= watchdog_error;
            end
            exit_step <= `EX_IDLE;
         end
         else if (in_fs)
         begin
            // freeze to defaults except kept fields
            general_control_one <= (CTRL_RESET & ~KEEP_MASK) |
               (general_control_one & KEEP_MASK);
            general_status_register <= general_status_register |
               failure_flags_in;
            if (exit_step != `EX_IDLE)
               wd_cnt <= wd_cnt + 16'h0001;
            if (fs_bad)
            begin
               serial_error_flag <= 1'b1;
               exit_step <= `EX_IDLE;
            end
            else if (clr_stat)
            begin
               negated_power_on_flag <= 1'b1;
               exit_step <= `EX_CLEARED;
               wd_cnt <= 16'h0000;
            end
            else if (wr_ctrl1)
            begin
               general_control_one[`WATCHDOG_TRIGGER_BIT_BIT] <= trig_val;
               wd_cnt <= 16'h0000;
               if (exit_step == `EX_CLEARED && trig_val)
                  exit_step <= `EX_TRIG1;
               else if (exit_step == `EX_TRIG1 && !trig_val)
               begin
                  exit_step <= `EX_IDLE;
                  fail_safe_flag <= 1'b0;
               end
               else
                  exit_step <= `EX_IDLE;
            end
            else if (exit_step != `EX_IDLE &&
               wd_cnt >= WD_CYC[15:0])
               exit_step <= `EX_IDLE;
         end
      end
   end
endmodule // gate_driver_mode_control

// File: tb/gdmc_asserts.sv
// Purpose: port-level checks of the gate driver mode controller
// Assumes: one clock domain, rst synchronous and active high
// Notes: attached by bind from the testbench top file
`timescale 1ns/1ps
`include "mode_ctrl_defs.vh"
module gdmc_asserts #(
   parameter CTRL_W = 16,
   parameter [CTRL_W-1:0] CTRL_RESET = 16'h0000,
   parameter [CTRL_W-1:0] KEEP_MASK = 16'h000f,
   parameter SETUP_CYC = 250
)(
   // clock, reset, pin
   input wire clk_sys,
   input wire rst,
   input wire en_pin,
   // frame, events and bridge timing
   input wire frame_valid,
   input wire [1:0] frame_kind,
   input wire [5:0] frame_addr,
   input wire watchdog_error,
   input wire [15:0] bridge_cross_current_time,
   // mode outputs
   input wire normal_mode,
   input wire sleep_mode,
   input wire fail_safe_mode,
   input wire drivers_enabled,
   input wire active_discharge,
   input wire passive_mode,
   input wire gate_pulldown_on,
   input wire charge_pump_on,
   input wire frame_accept,
   // register contents
   input wire [CTRL_W-1:0] general_control_one,
   input wire [15:0] general_status_register,
   input wire serial_error_flag,
   input wire charge_pump_undervoltage_flag,
   input wire negated_power_on_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   reg [15:0] en_hi_cnt;
   reg [15:0] dis_cnt;
   wire stat_clr = frame_valid && frame_kind == `FR_CLEAR &&
      frame_addr == `ADDR_GEN_STAT;
   // saturating run lengths: enable high, sleep-delay discharge
   always @(posedge clk_sys)
   begin
      en_hi_cnt <= (rst || !en_pin) ? 16'h0000 :
         en_hi_cnt + {15'h0000, en_hi_cnt != 16'hffff};
      dis_cnt <= (rst || !active_discharge || fail_safe_mode) ? 16'h0000 :
         dis_cnt + {15'h0000, dis_cnt != 16'hffff};
   end
   chk_setup_before_normal: assert property (
      $rose(normal_mode) |-> en_hi_cnt >= SETUP_CYC)
      else $error("normal mode before setup time");
   chk_sleep_delay_len: assert property (
      $rose(sleep_mode) |-> dis_cnt + 16'h0001 >=
      bridge_cross_current_time + `SLEEP_EXTRA_CYC)
      else $error("sleep entered too early");
   chk_sleep_regs_reset: assert property (
      sleep_mode && $past(sleep_mode) |-> general_control_one == CTRL_RESET)
      else $error("control register not reset in sleep");
   chk_sleep_gate_pulldown: assert property (
      sleep_mode |-> gate_pulldown_on && !drivers_enabled)
      else $error("gate pull-down off in sleep");
   chk_delay_no_accept: assert property (
      active_discharge && !fail_safe_mode |-> !frame_accept)
      else $error("frames accepted during sleep delay");
   chk_wd_enters_failsafe: assert property (
      normal_mode && watchdog_error |-> ##[1:2] fail_safe_mode && active_discharge)
      else $error("watchdog error did not enter fail-safe");
   chk_passive_pump_off: assert property (
      passive_mode && $past(passive_mode) |->
      !charge_pump_on && charge_pump_undervoltage_flag)
      else $error("pump running or flag clear in passive mode");
   chk_failsafe_frozen: assert property (
      fail_safe_mode && $past(fail_safe_mode) |->
      ((general_control_one ^ CTRL_RESET) & ~KEEP_MASK) == 0)
      else $error("frozen control bits changed in fail-safe");
   chk_failsafe_bad_write: assert property (
      fail_safe_mode && frame_valid && frame_kind == `FR_WRITE &&
      frame_addr != `ADDR_GEN_CTRL1 |-> ##[1:2] serial_error_flag)
      else $error("foreign write did not set serial error");
   chk_failsafe_flags_kept: assert property (
      fail_safe_mode && stat_clr |=> (general_status_register &
      $past(general_status_register)) == $past(general_status_register))
      else $error("status clear dropped failure flags");
   chk_clear_sets_negated_power_on_flag: assert property (
      normal_mode && stat_clr |-> ##[1:2] negated_power_on_flag)
      else $error("status clear left power-on flag low");
endmodule // gdmc_asserts

// File: tb/mcu_model.sv
// Purpose: controller side: enable pin and decoded frame strobes
// Assumes: frames are one-cycle strobes on clk_sys
// Notes: address and data lines take the inverse of the last frame's values once it ends
`timescale 1ns/1ps
`include "mode_ctrl_defs.vh"
module mcu_model (
   // clock and mode seen
   input wire clk_sys,
   input wire normal_mode,
   // enable and frame strobe
   output reg en_pin,
   output reg frame_valid,
   output reg [1:0] frame_kind,
   output reg [5:0] frame_addr,
   output reg [15:0] frame_data
);
   initial
   begin
      {en_pin, frame_valid, frame_kind, frame_addr, frame_data} = 0;
   end
   task frame(input [1:0] k, input [5:0] a, input [15:0] d);
   begin
      @(posedge clk_sys);
      {frame_valid, frame_kind, frame_addr, frame_data} <= {1'b1, k, a, d};
      @(posedge clk_sys);
      frame_valid <= 1'b0;
      // idle lines must not keep the old value
      frame_addr <= ~a;
      frame_data <= ~d;
   end
   endtask
   task power_up(output integer n);
   begin
      @(posedge clk_sys);
      en_pin <= 1'b1;
      for (n = 0; normal_mode !== 1'b1 && n < 400; n = n + 1)
         @(posedge clk_sys);
   end
   endtask
   task en_low(input integer len);
   begin
      @(posedge clk_sys);
      en_pin <= 1'b0;
      repeat (len) @(posedge clk_sys);
      en_pin <= (len == 0) ? 1'b0 : 1'b1;
   end
   endtask
   // steps back to back, well inside the watchdog period
   task exit_seq;
   begin
      frame(`FR_CLEAR, `ADDR_GEN_STAT, 16'h0000);
      frame(`FR_WRITE, `ADDR_GEN_CTRL1, 16'h0001);
      frame(`FR_WRITE, `ADDR_GEN_CTRL1, 16'h0000);
      frame(`FR_CLEAR, `ADDR_GEN_STAT, 16'h0000);
   end
   endtask
endmodule // mcu_model

// File: tb/tb_gate_driver_mode_control.sv
// Purpose: self-checking bench of the gate driver mode controller
// Assumes: short filter, setup and watchdog counts for simulation
// Notes: row table for normal-mode frames, hand tests for the rest
`timescale 1ns/1ps
`include "mode_ctrl_defs.vh"
module tb_gate_driver_mode_control;
   reg clk_sys, rst, watchdog_error;
   reg [15:0] bridge_cross_current_time, failure_flags_in;
   wire en_pin, frame_valid, frame_accept;
   wire [1:0] frame_kind;
   wire [5:0] frame_addr;
   wire [15:0] frame_data, general_control_one, general_status_register;
   wire normal_mode, sleep_mode, fail_safe_mode, drivers_enabled;
   wire active_discharge, passive_mode, gate_pulldown_on, charge_pump_on;
   wire fail_safe_flag, serial_error_flag, charge_pump_undervoltage_flag;
   wire negated_power_on_flag;
   integer failures = 0, num_checks = 0, cyc = 0, i, n;
   reg [40:0] rows [0:3];
   reg [1:0] k;
   reg [5:0] a;
   reg [15:0] d, e;
   reg p;
   gate_driver_mode_control #(.FILT_CYC(4), .SETUP_CYC(8), .WD_CYC(50))
      gate_driver_mode_control_inst (.clk_sys, .rst, .en_pin, .frame_valid,
      .frame_kind, .frame_addr, .frame_data, .watchdog_error,
      .bridge_cross_current_time, .failure_flags_in, .normal_mode,
      .sleep_mode, .fail_safe_mode, .drivers_enabled, .active_discharge,
      .passive_mode, .gate_pulldown_on, .charge_pump_on, .frame_accept,
      .general_control_one, .general_status_register, .fail_safe_flag,
      .serial_error_flag, .charge_pump_undervoltage_flag,
      .negated_power_on_flag);
   mcu_model mcu_model_inst (.clk_sys, .normal_mode, .en_pin, .frame_valid,
      .frame_kind, .frame_addr, .frame_data);
   initial
   begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   task results;
   begin
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         failures = failures + 1;
         results;
      end
   end
   task chk1(input got, input exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task chk16(input [15:0] got, input [15:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task wait_cyc(input integer c);
   begin
      repeat (c) @(posedge clk_sys);
      @(negedge clk_sys);
   end
   endtask
   initial
   begin
      rst = 1;
      watchdog_error = 0;
      bridge_cross_current_time = 16'h0010;
      failure_flags_in = 16'h0000;
      rows[0] = {`FR_WRITE, `ADDR_GEN_CTRL1, 16'h1234, 16'h1234, 1'b0};
      rows[1] = {`FR_READ, `ADDR_GEN_CTRL1, 16'h5555, 16'h1234, 1'b0};
      rows[2] = {`FR_CLEAR, `ADDR_GEN_STAT, 16'h0000, 16'h1234, 1'b1};
      rows[3] = {`FR_WRITE, `ADDR_GEN_CTRL1, 16'h00f0, 16'h00f0, 1'b1};
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      wait_cyc(1);
      chk1(sleep_mode & gate_pulldown_on, 1'b1);
      mcu_model_inst.power_up(n);
      wait_cyc(0);
      chk1(n >= 8, 1'b1);
      chk1(drivers_enabled, 1'b1);
      chk1(negated_power_on_flag, 1'b0);
      for (i = 0; i < 4; i = i + 1)
      begin
         {k, a, d, e, p} = rows[i];
         mcu_model_inst.frame(k, a, d);
         wait_cyc(1);
         chk16(general_control_one, e);
         chk1(negated_power_on_flag, p);
      end
      // glitch on enable shorter than the filter
      mcu_model_inst.en_low(2);
      wait_cyc(20);
      chk1(normal_mode, 1'b1);
      chk16(general_control_one, 16'h00f0);
      @(posedge clk_sys);
      failure_flags_in <= 16'h0040;
      watchdog_error <= 1'b1;
      @(posedge clk_sys);
      {failure_flags_in, watchdog_error} <= 17'h00000;
      wait_cyc(2);
      chk1(fail_safe_mode & fail_safe_flag & active_discharge, 1'b1);
      wait_cyc(24);
      chk1(passive_mode & charge_pump_undervoltage_flag, 1'b1);
      chk1(charge_pump_on | drivers_enabled, 1'b0);
      chk16(general_control_one & 16'hfff0, 16'h0000);
      mcu_model_inst.frame(`FR_READ, `ADDR_GEN_STAT, 16'h0000);
      wait_cyc(1);
      chk1(serial_error_flag, 1'b0);
      // broken exit: a foreign write in the middle
      mcu_model_inst.frame(`FR_CLEAR, `ADDR_GEN_STAT, 16'h0000);
      mcu_model_inst.frame(`FR_WRITE, 6'h01, 16'h00ff);
      mcu_model_inst.frame(`FR_WRITE, `ADDR_GEN_CTRL1, 16'h0001);
      mcu_model_inst.frame(`FR_WRITE, `ADDR_GEN_CTRL1, 16'h0000);
      wait_cyc(2);
      chk16(general_status_register & 16'h0040, 16'h0040);
      chk1(serial_error_flag, 1'b1);
      chk1(fail_safe_mode, 1'b1);
      mcu_model_inst.exit_seq;
      wait_cyc(4);
      chk1(fail_safe_mode | fail_safe_flag, 1'b0);
      chk1(normal_mode & drivers_enabled, 1'b1);
      mcu_model_inst.en_low(0);
      for (n = 0; active_discharge !== 1'b1 && n < 30; n = n + 1)
         wait_cyc(0);
      mcu_model_inst.frame(`FR_WRITE, `ADDR_GEN_CTRL1, 16'h0ff0);
      for (n = 2; sleep_mode !== 1'b1 && n < 300; n = n + 1)
         wait_cyc(0);
      chk1(n + 1 >= 16 + `SLEEP_EXTRA_CYC, 1'b1);
      chk1(gate_pulldown_on, 1'b1);
      chk16(general_control_one, 16'h0000);
      mcu_model_inst.power_up(n);
      wait_cyc(0);
      chk1(negated_power_on_flag, 1'b0);
      mcu_model_inst.frame(`FR_CLEAR, `ADDR_GEN_STAT, 16'h0000);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      wait_cyc(1);
      chk1(normal_mode | negated_power_on_flag, 1'b0);
      results;
   end
endmodule // tb_gate_driver_mode_control
bind gate_driver_mode_control gdmc_asserts #(.CTRL_W(CTRL_W),
   .CTRL_RESET(CTRL_RESET), .KEEP_MASK(KEEP_MASK), .SETUP_CYC(SETUP_CYC))
   gdmc_asserts_inst (.clk_sys, .rst, .en_pin, .frame_valid, .frame_kind,
   .frame_addr, .watchdog_error, .bridge_cross_current_time, .normal_mode,
   .sleep_mode, .fail_safe_mode, .drivers_enabled, .active_discharge,
   .passive_mode, .gate_pulldown_on, .charge_pump_on, .frame_accept,
   .general_control_one, .general_status_register, .serial_error_flag,
   .charge_pump_undervoltage_flag, .negated_power_on_flag);
